// file: user_flash_program_control.sv
// Flash control and status registers, unlock sequencer and write routing.
// Assumes one-cycle register strobes from the core and a flash array
// that accepts one byte per cycle on the program port.
`include "flash_ctl_defines.svh"
module user_flash_program_control
	import flash_ctl_pkg::*;
#(
	parameter int PROG_CYCLES = `PROG_CYCLES
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_hit_o,
	input wire logic data_ram_select_bit_i,
	input wire logic xdata_wr_i,
	input wire logic [15:0] xdata_addr_i,
	input wire logic [7:0] xdata_wdata_i,
	output logic ext_xdata_wr_o,
	output logic int_xdata_wr_o,
	input wire logic exec_boot_i,
	input wire logic exec_external_i,
	input wire logic ext_read_allowed_i,
	input wire logic code_rd_i,
	input wire logic [15:0] code_addr_i,
	output logic [15:0] flash_rd_addr_o,
	output logic [1:0] flash_rd_space_o,
	output logic flash_rd_en_o,
	output logic prog_wr_o,
	output logic [15:0] prog_addr_o,
	output logic [7:0] prog_data_o,
	output logic [1:0] prog_space_o,
	output logic prog_busy_o
);
	flash_control_t ctl_reg, ctl_next;
	logic seq_err_reg, seq_err_next;
	logic loaded_reg, loaded_next;
	launch_state_t state_reg, state_next;
	logic [31:0] wait_reg, wait_next;
	logic [6:0] idx_reg, idx_next;
	flash_mode_t op_mode_reg, op_mode_next;
	logic [8:0] page_reg, page_next;
	logic [15:0] prog_addr_reg, prog_addr_next;
	logic [7:0] prog_data_reg, prog_data_next;
	logic prog_wr_reg, prog_wr_next;
	logic [15:0] rd_addr_reg, rd_addr_next;
	logic [1:0] rd_space_reg, rd_space_next;
	logic rd_en_reg, rd_en_next;
	logic [7:0] rdata_reg, rdata_next;

	logic ctl_wr, stat_wr, latch_wr, latch_clear;
	logic [3:0] launch_val;
	logic [7:0] lat_byte;
	logic lat_valid;
	latch_write_t lat_wr_data;

	// Decode of the two special function registers
	assign ctl_wr = sfr_wr_i && (sfr_addr_i == `FCTL_ADDR);
	assign stat_wr = sfr_wr_i && (sfr_addr_i == `FSTAT_ADDR);
	assign sfr_hit_o = (sfr_addr_i == `FCTL_ADDR) || (sfr_addr_i == `FSTAT_ADDR);
	assign launch_val = sfr_wdata_i[`FCTL_LAUNCH_LSB +: 4];

	// Map bit wins over the RAM select bit when steering data writes
	assign latch_wr = xdata_wr_i && ctl_reg.map;
	assign ext_xdata_wr_o = xdata_wr_i && !ctl_reg.map && data_ram_select_bit_i;
	assign int_xdata_wr_o = xdata_wr_i && !ctl_reg.map && !data_ram_select_bit_i;
	assign lat_wr_data.offset = xdata_addr_i[6:0];
	assign lat_wr_data.data = xdata_wdata_i;

	// Register, sequencer and programming engine next state
	always_comb begin
		ctl_next = ctl_reg;
		seq_err_next = seq_err_reg;
		loaded_next = loaded_reg;
		state_next = state_reg;
		wait_next = wait_reg;
		idx_next = idx_reg;
		op_mode_next = op_mode_reg;
		page_next = page_reg;
		prog_addr_next = prog_addr_reg;
		prog_data_next = prog_data_reg;
		prog_wr_next = 1'b0;
		latch_clear = 1'b0;
		if (latch_wr) begin
			if (!loaded_reg) begin
				loaded_next = 1'b1;
			end
			page_next = xdata_addr_i[15:7];
		end
		// Software clear of the error; a set in the same cycle wins below
		if (stat_wr && !sfr_wdata_i[`FSTAT_SEQ_BIT]) begin
			seq_err_next = 1'b0;
		end
		case (state_reg)
			ST_IDLE: begin
				if (ctl_wr) begin
					ctl_next.map = sfr_wdata_i[`FCTL_MAP_BIT];
					ctl_next.mode = flash_mode_t'(sfr_wdata_i[`FCTL_MODE_LSB +: 2]);
					ctl_next.launch = launch_val;
					if (launch_val == `LAUNCH_FIRST) begin
						state_next = ST_ARMED;
					end else if (launch_val == `LAUNCH_SECOND) begin
						seq_err_next = 1'b1;
					end
				end
			end
			ST_ARMED: begin
				if (ctl_wr) begin
					ctl_next.map = sfr_wdata_i[`FCTL_MAP_BIT];
					ctl_next.mode = flash_mode_t'(sfr_wdata_i[`FCTL_MODE_LSB +: 2]);
					ctl_next.launch = launch_val;
					if (launch_val == `LAUNCH_SECOND) begin
						seq_err_next = 1'b0;
						loaded_next = 1'b0;
						op_mode_next = ctl_next.mode;
						state_next = ST_IDLE;
						if (ctl_next.mode == MODE_LATCH_RESET) begin
							latch_clear = 1'b1;
						end else if (exec_boot_i) begin
							// Other execution sources get no programming effect
							state_next = ST_PROGRAM;
							ctl_next.busy = 1'b1;
							idx_next = '0;
							wait_next = '0;
						end
					end else if (launch_val != `LAUNCH_FIRST) begin
						seq_err_next = 1'b1;
						state_next = ST_IDLE;
					end
				end
			end
			ST_PROGRAM: begin
				// Launch field writes are dropped until done; map and mode still update
				if (ctl_wr) begin
					ctl_next.map = sfr_wdata_i[`FCTL_MAP_BIT];
					ctl_next.mode = flash_mode_t'(sfr_wdata_i[`FCTL_MODE_LSB +: 2]);
				end
				if (wait_reg == 32'(PROG_CYCLES - 1)) begin
					ctl_next.busy = 1'b0;
					state_next = ST_IDLE;
					latch_clear = 1'b1;
				end else begin
					wait_next = wait_reg + 32'h1;
				end
				// Stream marked latch bytes out to the array, one per cycle
				if (wait_reg < 32'(`PAGE_BYTES)) begin
					idx_next = idx_reg + 7'h1;
					prog_wr_next = lat_valid;
					prog_data_next = lat_byte;
					case (op_mode_reg)
						MODE_USER: prog_addr_next = {page_reg, idx_reg};
						MODE_XROW: prog_addr_next = `XROW_BASE | {9'h000, idx_reg};
						default: prog_addr_next = 16'h0000;
					endcase
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Control state registers
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctl_reg <= `FCTL_RESET;
			seq_err_reg <= 1'b0;
			loaded_reg <= 1'b0;
			state_reg <= ST_IDLE;
			wait_reg <= '0;
			idx_reg <= '0;
			op_mode_reg <= MODE_USER;
			page_reg <= '0;
			prog_addr_reg <= '0;
			prog_data_reg <= '0;
			prog_wr_reg <= 1'b0;
		end else begin
			ctl_reg <= ctl_next;
			seq_err_reg <= seq_err_next;
			loaded_reg <= loaded_next;
			state_reg <= state_next;
			wait_reg <= wait_next;
			idx_reg <= idx_next;
			op_mode_reg <= op_mode_next;
			page_reg <= page_next;
			prog_addr_reg <= prog_addr_next;
			prog_data_reg <= prog_data_next;
			prog_wr_reg <= prog_wr_next;
		end
	end

	column_latch u_latch (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.wr_i(latch_wr),
		.wr_data_i(lat_wr_data),
		.clear_i(latch_clear),
		.rd_index_i(idx_reg),
		.rd_data_o(lat_byte),
		.rd_valid_o(lat_valid)
	);

	// Code-space read window and register read data
	always_comb begin
		rd_space_next = ctl_reg.mode;
		rd_en_next = 1'b0;
		rd_addr_next = code_addr_i;
		rdata_next = rdata_reg;
		if (code_rd_i) begin
			// Latches are never visible here; external code obeys lock bits
			rd_en_next = !exec_external_i || ext_read_allowed_i;
			case (ctl_reg.mode)
				MODE_USER: rd_addr_next = code_addr_i;
				MODE_XROW: rd_addr_next = `XROW_BASE | {9'h000, code_addr_i[6:0]};
				MODE_SECURITY: rd_addr_next = 16'h0000;
				default: rd_en_next = 1'b0;
			endcase
		end
		if (sfr_rd_i) begin
			if (sfr_addr_i == `FCTL_ADDR) begin
				rdata_next = ctl_reg;
			end else if (sfr_addr_i == `FSTAT_ADDR) begin
				rdata_next = {6'h00, seq_err_reg, loaded_reg};
			end else begin
				rdata_next = 8'h00;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_space_reg <= 2'h0;
			rd_en_reg <= 1'b0;
			rd_addr_reg <= '0;
			rdata_reg <= 8'h00;
		end else begin
			rd_space_reg <= rd_space_next;
			rd_en_reg <= rd_en_next;
			rd_addr_reg <= rd_addr_next;
			rdata_reg <= rdata_next;
		end
	end

	assign sfr_rdata_o = rdata_reg;
	assign flash_rd_addr_o = rd_addr_reg;
	assign flash_rd_space_o = rd_space_reg;
	assign flash_rd_en_o = rd_en_reg;
	assign prog_wr_o = prog_wr_reg;
	assign prog_addr_o = prog_addr_reg;
	assign prog_data_o = prog_data_reg;
	assign prog_space_o = op_mode_reg;
	assign prog_busy_o = ctl_reg.busy;
endmodule : user_flash_program_control

// file: flash_ctl_defines.svh
// Constants for the user flash program control block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef FLASH_CTL_DEFINES_SVH
`define FLASH_CTL_DEFINES_SVH
`define FCTL_ADDR 8'hD1
`define FSTAT_ADDR 8'hD3
`define FCTL_RESET 8'h00
`define FSTAT_RESET 8'h00
`define FCTL_BUSY_BIT 0
`define FCTL_MODE_LSB 1
`define FCTL_MAP_BIT 3
`define FCTL_LAUNCH_LSB 4
`define FSTAT_LOAD_BIT 0
`define FSTAT_SEQ_BIT 1
`define LAUNCH_FIRST 4'h5
`define LAUNCH_SECOND 4'hA
`define PAGE_BYTES 128
`define XROW_BASE 16'hFF80
`define PROG_TIME_US 16
`define CLK_MHZ 125
`define PROG_CYCLES ((`PROG_TIME_US) * (`CLK_MHZ))
`endif

// file: flash_ctl_pkg.sv
// Types shared by the flash program control modules.
// Assumes the constants header sits in the same folder.
`include "flash_ctl_defines.svh"
package flash_ctl_pkg;
	typedef enum logic [1:0] {
		MODE_USER = 2'h0,
		MODE_XROW = 2'h1,
		MODE_SECURITY = 2'h2,
		MODE_LATCH_RESET = 2'h3
	} flash_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ARMED = 2'h1,
		ST_PROGRAM = 2'h3
	} launch_state_t;
	typedef struct packed {
		logic [3:0] launch;
		logic map;
		flash_mode_t mode;
		logic busy;
	} flash_control_t;
	typedef struct packed {
		logic [6:0] offset;
		logic [7:0] data;
	} latch_write_t;
	typedef struct packed {
		logic start;
		flash_mode_t mode;
		logic [8:0] page;
	} program_request_t;
endpackage : flash_ctl_pkg

// file: column_latch.sv
// Page-wide write buffer with per-byte written marks.
// Assumes writes and clears come from the flash control block.
`include "flash_ctl_defines.svh"
module column_latch
	import flash_ctl_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic wr_i,
	input latch_write_t wr_data_i,
	input wire logic clear_i,
	input wire logic [6:0] rd_index_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o
);
	logic [7:0] mem_reg [`PAGE_BYTES];
	logic [7:0] mem_next [`PAGE_BYTES];
	logic [`PAGE_BYTES-1:0] mark_reg;
	logic [`PAGE_BYTES-1:0] mark_next;

	// Only the programming engine reads back; software cannot
	always_comb begin
		mem_next = mem_reg;
		mark_next = mark_reg;
		if (clear_i) begin
			mark_next = '0;
		end
		if (wr_i) begin
			mem_next[wr_data_i.offset] = wr_data_i.data;
			mark_next[wr_data_i.offset] = 1'b1;
		end
	end

	// Data bytes carry no reset, marks do
	always_ff @(posedge mclk_i) begin
		mem_reg <= mem_next;
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mark_reg <= '0;
		end else begin
			mark_reg <= mark_next;
		end
	end

	assign rd_data_o = mem_reg[rd_index_i];
	assign rd_valid_o = mark_reg[rd_index_i];
endmodule : column_latch

// file: user_flash_program_control_chk.sv
// Port checker for the flash program control block.
// Assumes it is bound onto user_flash_program_control.
module user_flash_program_control_chk (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic sfr_hit_o,
	input wire logic data_ram_select_bit_i,
	input wire logic xdata_wr_i,
	input wire logic ext_xdata_wr_o,
	input wire logic int_xdata_wr_o,
	input wire logic exec_boot_i,
	input wire logic exec_external_i,
	input wire logic ext_read_allowed_i,
	input wire logic code_rd_i,
	input wire logic [15:0] code_addr_i,
	input wire logic [15:0] flash_rd_addr_o,
	input wire logic [1:0] flash_rd_space_o,
	input wire logic flash_rd_en_o,
	input wire logic prog_wr_o,
	input wire logic prog_busy_o
);
	logic map_reg, map_next;
	logic [1:0] mode_reg, mode_next;
	// Shadow of map bit and mode field; busy never blocks these fields
	always_comb begin
		map_next = map_reg;
		mode_next = mode_reg;
		if (sfr_wr_i && sfr_addr_i == 8'hD1) begin
			map_next = sfr_wdata_i[3];
			mode_next = sfr_wdata_i[2:1];
		end
	end
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			map_reg <= 1'b0;
			mode_reg <= 2'h0;
		end else begin
			map_reg <= map_next;
			mode_reg <= mode_next;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	hit_decode_a: assert property (sfr_hit_o == (sfr_addr_i inside {8'hD1, 8'hD3}))
		else $error("Hit flag wrong");
	unmapped_read_a: assert property (sfr_rd_i && !sfr_hit_o |=> sfr_rdata_o == 8'h00)
		else $error("Unmapped read not zero");
	busy_readback_a: assert property (sfr_rd_i && sfr_addr_i == 8'hD1
		|=> sfr_rdata_o[0] == $past(prog_busy_o)) else $error("Busy bit readback wrong");
	latch_route_a: assert property (xdata_wr_i && map_reg
		|-> !ext_xdata_wr_o && !int_xdata_wr_o) else $error("Latch write leaked");
	plain_route_a: assert property (xdata_wr_i && !map_reg |-> ext_xdata_wr_o ==
		data_ram_select_bit_i && int_xdata_wr_o == !data_ram_select_bit_i) else $error("Route");
	boot_only_a: assert property ($rose(prog_busy_o)
		|-> $past(exec_boot_i) && $past(mode_reg) != 2'h3) else $error("Bad launch");
	prog_in_busy_a: assert property (prog_wr_o |-> prog_busy_o)
		else $error("Program write outside busy");
	busy_hold_a: assert property ($rose(prog_busy_o) |-> prog_busy_o [*8])
		else $error("Busy dropped early");
	mode_read_a: assert property (code_rd_i && mode_reg != 2'h3 && !exec_external_i
		|=> flash_rd_en_o && flash_rd_space_o == $past(mode_reg)) else $error("Read space");
	user_addr_a: assert property (code_rd_i && mode_reg == 2'h0 && !exec_external_i
		|=> flash_rd_addr_o == $past(code_addr_i)) else $error("Read address wrong");
	latch_reset_a: assert property (code_rd_i && mode_reg == 2'h3 |=> !flash_rd_en_o)
		else $error("Read in latch reset mode");
	lock_read_a: assert property (code_rd_i && exec_external_i && mode_reg == 2'h0
		|=> flash_rd_en_o == $past(ext_read_allowed_i)) else $error("Lock read wrong");
endmodule : user_flash_program_control_chk
bind user_flash_program_control user_flash_program_control_chk chk (.*);

// file: core_model.sv
// Core-side model driving register, data-write and code-read strobes.
// Assumes the block takes each strobe at one rising mclk_i edge.
module core_model (
	input wire logic mclk_i,
	input wire logic [7:0] sfr_rdata_o,
	output logic sfr_wr_i,
	output logic sfr_rd_i,
	output logic [7:0] sfr_addr_i,
	output logic [7:0] sfr_wdata_i,
	output logic xdata_wr_i,
	output logic [15:0] xdata_addr_i,
	output logic [7:0] xdata_wdata_i,
	output logic code_rd_i,
	output logic [15:0] code_addr_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus from time zero
	initial begin
		{sfr_wr_i, sfr_rd_i, xdata_wr_i, code_rd_i} = 4'h0;
		{sfr_addr_i, sfr_wdata_i, xdata_addr_i, xdata_wdata_i, code_addr_i} = '0;
	end
	// Strobe held one edge; data inverted after so stale values never match
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		#1 {sfr_addr_i, sfr_wdata_i, sfr_wr_i} = {a, d, 1'b1};
		@(posedge mclk_i);
		#1 {sfr_wdata_i, sfr_wr_i} = {~d, 1'b0};
	endtask : sfr_write
	task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		#1 {sfr_addr_i, sfr_rd_i} = {a, 1'b1};
		@(posedge mclk_i);
		#1 sfr_rd_i = 1'b0;
		d = sfr_rdata_o;
	endtask : sfr_read
	task automatic xdata_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		#1 {xdata_addr_i, xdata_wdata_i, xdata_wr_i} = {a, d, 1'b1};
		@(posedge mclk_i);
		#1 {xdata_wdata_i, xdata_wr_i} = {~d, 1'b0};
	endtask : xdata_write
	task automatic code_read(input logic [15:0] a);
		@(posedge mclk_i);
		#1 {code_addr_i, code_rd_i} = {a, 1'b1};
		@(posedge mclk_i);
		#1 {code_addr_i, code_rd_i} = {~a, 1'b0};
	endtask : code_read
endmodule : core_model

// file: user_flash_program_control_test.sv
// Self-checking bench for the flash program control block.
// Assumes the core model drives all strobes; exec and lock inputs set here.
module user_flash_program_control_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk_i, sys_rst_i, data_ram_select_bit_i, exec_boot_i, exec_external_i;
	logic ext_read_allowed_i, sfr_wr_i, sfr_rd_i, xdata_wr_i, code_rd_i, sfr_hit_o;
	logic ext_xdata_wr_o, int_xdata_wr_o, flash_rd_en_o, prog_wr_o, prog_busy_o;
	logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, xdata_wdata_i, prog_data_o;
	logic [15:0] xdata_addr_i, code_addr_i, flash_rd_addr_o, prog_addr_o;
	logic [1:0] flash_rd_space_o, prog_space_o;
	logic [7:0] d;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	logic [1:0] route_seen;
	user_flash_program_control #(.PROG_CYCLES(140)) DUT (.*);
	core_model core (.*);
	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end
	// Routed strobes are combinational and live one cycle, so latch them at the taking edge
	always @(posedge mclk_i) begin
		if (xdata_wr_i) route_seen <= {ext_xdata_wr_o, int_xdata_wr_o};
	end
	// Hang guard: ceiling well above the few hundred cycles the tests need
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic t_regs();
		core.sfr_read(8'hD1, d);
		check(d, 8'h00);
		core.sfr_read(8'hD3, d);
		check(d, 8'h00);
		core.sfr_read(8'hD2, d);
		check(d, 8'h00);
		core.sfr_write(8'hD1, 8'h01);
		core.sfr_read(8'hD1, d);
		check(d, 8'h00);
		$display("Register test done");
	endtask : t_regs
	task automatic t_program();
		core.sfr_write(8'hD1, 8'h08);
		core.xdata_write(16'hFFFF, 8'h5A);
		core.sfr_read(8'hD3, d);
		check(d, 8'h01);
		core.sfr_write(8'hD1, 8'h50);
		core.sfr_write(8'hD1, 8'hA0);
		core.sfr_read(8'hD1, d);
		check(d[0], 1'b1);
		core.sfr_read(8'hD3, d);
		check(d, 8'h00);
		for (int n = 0; n < 200 && prog_wr_o !== 1'b1; n++) @(posedge mclk_i) #1;
		check({prog_addr_o}, 16'hFFFF);
		check({prog_data_o, 6'h0, prog_space_o}, 16'h5A00);
		// A second pair while busy must not start another run
		core.sfr_write(8'hD1, 8'h52);
		core.sfr_write(8'hD1, 8'hA2);
		for (int n = 0; n < 300 && prog_busy_o !== 1'b0; n++) @(posedge mclk_i) #1;
		repeat (5) @(posedge mclk_i);
		check(prog_busy_o, 1'b0);
		$display("Program test done");
	endtask : t_program
	task automatic t_sequence();
		core.sfr_write(8'hD1, 8'hA0);
		core.sfr_read(8'hD3, d);
		check(d, 8'h02);
		core.sfr_write(8'hD3, 8'h00);
		core.sfr_read(8'hD3, d);
		check(d, 8'h00);
		core.sfr_write(8'hD1, 8'h50);
		core.sfr_write(8'hD1, 8'h30);
		core.sfr_write(8'hD1, 8'h08);
		core.xdata_write(16'h0080, 8'h11);
		core.sfr_read(8'hD3, d);
		check(d, 8'h03);
		core.sfr_write(8'hD1, 8'h56);
		core.sfr_write(8'hD1, 8'hA6);
		core.sfr_read(8'hD3, d);
		check({d, 7'h0, prog_busy_o}, 16'h0000);
		exec_boot_i = 1'b0;
		core.sfr_write(8'hD1, 8'h58);
		core.xdata_write(16'h0100, 8'h22);
		core.sfr_write(8'hD1, 8'h50);
		core.sfr_write(8'hD1, 8'hA0);
		core.sfr_read(8'hD3, d);
		check({d, 7'h0, prog_busy_o}, 16'h0000);
		exec_boot_i = 1'b1;
		$display("Sequence test done");
	endtask : t_sequence
	task automatic t_route();
		for (int i = 0; i < 4; i++) begin
			data_ram_select_bit_i = i[0];
			core.sfr_write(8'hD1, {4'h0, i[1], 3'h0});
			core.xdata_write(16'h0200, 8'h33);
			check(route_seen, i[1] ? 2'h0 : {i[0], !i[0]});
		end
		$display("Route test done");
	endtask : t_route
	task automatic t_code();
		for (int m = 0; m < 4; m++) begin
			core.sfr_write(8'hD1, {5'h0, m[1:0], 1'b0});
			core.code_read(16'h0100);
			check({flash_rd_en_o, flash_rd_space_o}, (m == 3) ? 3'h3 : {1'b1, m[1:0]});
		end
		core.sfr_write(8'hD1, 8'h00);
		exec_external_i = 1'b1;
		for (int a = 0; a < 2; a++) begin
			ext_read_allowed_i = a[0];
			core.code_read(16'h1234);
			check(flash_rd_en_o, a[0]);
		end
		exec_external_i = 1'b0;
		$display("Code read test done");
	endtask : t_code
	initial begin
		{data_ram_select_bit_i, exec_external_i, ext_read_allowed_i} = 3'h0;
		exec_boot_i = 1'b1;
		sys_rst_i = 1'b1;
		repeat (4) @(posedge mclk_i);
		#1 sys_rst_i = 1'b0;
		t_regs();
		t_program();
		t_sequence();
		t_route();
		t_code();
		give_verdict();
	end
endmodule : user_flash_program_control_test
